// >>> src/irq_frame_pkg.sv
// Package: register map, field positions and timing for the interrupt/frame index block
`default_nettype none
package irq_frame_pkg;
    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] OFF_STATUS   = 8'h14;
    localparam logic [7:0] OFF_ENABLE   = 8'h18;
    localparam logic [7:0] OFF_UF_IDX   = 8'h1C;
    localparam logic [7:0] OFF_CONTROL  = 8'h20;
    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int BIT_XFER_DONE  = 0;
    localparam int BIT_XFER_ERR   = 1;
    localparam int BIT_PORT_CHG   = 2;
    localparam int BIT_LIST_WRAP  = 3;
    localparam int BIT_SYS_ERR    = 4;
    localparam int BIT_ASYNC_ADV  = 5;
    localparam int BIT_STOPPED    = 12;
    localparam int BIT_RUN        = 0;
    localparam int POS_LIST_SIZE  = 2;
    localparam int POS_THRESHOLD  = 16;
    localparam int SRC_W          = 6;
    localparam int FRIDX_W        = 14;
    localparam int THR_W          = 8;
    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [SRC_W-1:0]   RST_ENABLE    = 6'h00;
    localparam logic [SRC_W-1:0]   RST_PENDING   = 6'h00;
    localparam logic [FRIDX_W-1:0] RST_UF_IDX    = 14'h0000;
    localparam logic [THR_W-1:0]   RST_THRESHOLD = 8'h01;
    localparam logic               RST_STOPPED   = 1'b1;
    // Sources released at the threshold boundary: async advance, error, done
    localparam logic [SRC_W-1:0]   THR_GOVERNED  = 6'h23;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_HZ        = 20000000;
    localparam int UFRAME_NS     = 125000;
    localparam int UFRAME_CYCLES = UFRAME_NS / (1000000000 / CLK_HZ);
    localparam int STOP_CYCLES   = 1;

    typedef struct packed {
        logic [7:0]  addr;
        logic        write;
        logic [31:0] wdata;
        logic        sel;
        logic        enable;
    } apb_req_type;

    typedef struct packed {
        logic [SRC_W-1:0] events;
        logic             port_change_level;
    } src_in_type;
endpackage
`default_nettype wire

// >>> src/irq_frame_core.sv
// Interrupt enable, gating and micro-frame index logic behind an APB slave
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Enabled source with pending flag raises the interrupt.
// - Disabled sources still set their pending flags for polling.
// - Async advance interrupt waits for the threshold boundary.
// - System error interrupts immediately.
// - List wrap interrupts immediately.
// - Port change interrupts immediately.
// - Transfer error interrupt waits for the threshold boundary.
// - Transfer done interrupt waits for the threshold boundary.
// - Threshold of one releases governed events with no added delay.
// - Frame index advances once every 125 us while running.
// - Frame index writes only land while the controller is stopped.
// - Bits N down to 3 form the list index, eight micro-frames each.
// - List size 0,1,2 gives N of 12,11,10; 3 is reserved.
// - List index wrap to zero sets the list wrap flag.
// - Writing one clears a pending flag; zero leaves it.
// - Stopped flag reads zero while running, set after stopping.
module irq_frame_core
    import irq_frame_pkg::*;
(
    input  wire logic                  CLK_SYS,
    input  wire logic                  RST,
    input  wire logic                  PSEL,
    input  wire logic                  PENABLE,
    input  wire logic                  PWRITE,
    input  wire logic [7:0]            PADDR,
    input  wire logic [31:0]           PWDATA,
    output logic      [31:0]           PRDATA,
    output logic                       PREADY,
    output logic                       PSLVERR,
    input  wire logic [SRC_W-1:0]      EVENT_PULSE,
    output logic                       IRQ,
    output logic      [FRIDX_W-1:0]    FRAME_INDEX,
    output logic      [9:0]            LIST_INDEX
);
    // ************************************************************
    // Functions
    // ************************************************************
    function automatic logic [FRIDX_W-1:0] wrap_mask(input logic [1:0] size);
        case (size)
            2'b00:   wrap_mask = 14'h1FFF;
            2'b01:   wrap_mask = 14'h0FFF;
            2'b10:   wrap_mask = 14'h07FF;
            default: wrap_mask = 14'h1FFF;
        endcase
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    typedef enum logic [1:0] {
        RUNNING  = 2'b01,
        STOPPED  = 2'b10
    } run_state_type;

    apb_req_type          req;
    run_state_type        run_q, run_d;
    logic [SRC_W-1:0]     enable_q, enable_d;
    logic [SRC_W-1:0]     pending_q, pending_d;
    logic [FRIDX_W-1:0]   uf_idx_q, uf_idx_d;
    logic [THR_W-1:0]     threshold_q, threshold_d;
    logic [THR_W-1:0]     thr_cnt_q, thr_cnt_d;
    logic [1:0]           list_size_q, list_size_d;
    logic                 run_bit_q, run_bit_d;
    logic                 irq_q, irq_d;
    logic [12:0]          tick_cnt_q, tick_cnt_d;
    logic [31:0]          rdata_q, rdata_d;
    logic [SRC_W-1:0]     ev_s1_q, ev_s2_q;
    logic                 tick;
    logic                 boundary;
    logic                 wr_en;
    logic [FRIDX_W-1:0]   uf_idx_inc;
    logic [SRC_W-1:0]     set_vec;
    logic [SRC_W-1:0]     active;
    logic                 halted;

    assign req     = '{addr: PADDR, write: PWRITE, wdata: PWDATA, sel: PSEL, enable: PENABLE};
    assign wr_en   = req.sel && req.enable && req.write;
    assign PREADY  = 1'b1;
    assign PSLVERR = 1'b0;
    assign PRDATA  = rdata_q;

    // Event pins come from other logic domains
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ev_s1_q <= RST_PENDING;
            ev_s2_q <= RST_PENDING;
        end else begin
            ev_s1_q <= EVENT_PULSE;
            ev_s2_q <= ev_s1_q;
        end
    end

    // ************************************************************
    // Micro-frame timer and frame index
    // ************************************************************
    // micro-frame tick
    assign tick        = (run_q == RUNNING) && (tick_cnt_q == 13'(UFRAME_CYCLES - 1));
    assign uf_idx_inc  = uf_idx_q + 14'h0001;

    always_comb begin
        tick_cnt_d = tick_cnt_q;
        uf_idx_d   = uf_idx_q;
        if (run_q == RUNNING) begin
            tick_cnt_d = tick ? 13'h0000 : tick_cnt_q + 13'h0001;
        end else begin
            tick_cnt_d = 13'h0000;
        end
        if (tick) begin
            uf_idx_d = uf_idx_inc;
        end
        if (wr_en && req.addr == OFF_UF_IDX && halted) begin
            uf_idx_d = req.wdata[FRIDX_W-1:0];
        end
    end

    // ************************************************************
    // Run control and stopped flag
    // ************************************************************
    // stopped follows run bit one cycle later
    always_comb begin
        run_d = run_q;
        case (run_q)
            RUNNING: run_d = run_bit_q ? RUNNING : STOPPED;
            STOPPED: run_d = run_bit_q ? RUNNING : STOPPED;
            default: run_d = STOPPED;
        endcase
    end
    // halted only with run bit clear, so a fresh run never reads halted
    assign halted = (run_q == STOPPED) && !run_bit_q;

    // ************************************************************
    // Threshold boundary counter
    // ************************************************************
    // threshold of one means every cycle is a boundary
    assign boundary = (threshold_q <= 8'h01) || (thr_cnt_q >= threshold_q - 8'h01);
    always_comb begin
        thr_cnt_d = boundary ? 8'h00 : thr_cnt_q + 8'h01;
    end

    // ************************************************************
    // Pending flags and enables
    // ************************************************************
    always_comb begin
        set_vec = ev_s2_q;
        // list index wrap sets the wrap flag
        if (tick && ((uf_idx_q & wrap_mask(list_size_q)) == wrap_mask(list_size_q))) begin
            set_vec[BIT_LIST_WRAP] = 1'b1;
        end
        pending_d   = pending_q;
        enable_d    = enable_q;
        threshold_d = threshold_q;
        list_size_d = list_size_q;
        run_bit_d   = run_bit_q;
        if (wr_en && req.addr == OFF_STATUS) begin
            pending_d = pending_q & ~req.wdata[SRC_W-1:0];
        end
        // flags set regardless of enables; set beats clear
        pending_d = pending_d | set_vec;
        if (wr_en && req.addr == OFF_ENABLE) begin
            enable_d = req.wdata[SRC_W-1:0];
        end
        if (wr_en && req.addr == OFF_CONTROL) begin
            run_bit_d   = req.wdata[BIT_RUN];
            list_size_d = req.wdata[POS_LIST_SIZE +: 2];
            threshold_d = req.wdata[POS_THRESHOLD +: THR_W];
        end
    end

    // ************************************************************
    // Interrupt output
    // ************************************************************
    assign active = enable_q & pending_q;
    always_comb begin
        irq_d = |(active & ~THR_GOVERNED);
        // governed sources wait for a boundary
        if (|(active & THR_GOVERNED)) begin
            irq_d = irq_d || boundary || irq_q;
        end
        // falls once no enabled source is pending
        if (active == '0) begin
            irq_d = 1'b0;
        end
    end
    assign IRQ = irq_q;

    // ************************************************************
    // Read data
    // ************************************************************
    always_comb begin
        rdata_d = rdata_q;
        if (req.sel && !req.enable && !req.write) begin
            case (req.addr)
                OFF_STATUS: begin
                    rdata_d = 32'h0000_0000;
                    rdata_d[SRC_W-1:0]  = pending_q;
                    rdata_d[BIT_STOPPED] = halted;
                end
                OFF_ENABLE:  rdata_d = {26'h0, enable_q};
                OFF_UF_IDX:  rdata_d = {18'h0, uf_idx_q};
                OFF_CONTROL: rdata_d = {8'h0, threshold_q, 12'h0, list_size_q, 1'b0, run_bit_q};
                default:     rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        case (list_size_q)
            2'b01:   LIST_INDEX = {1'b0, uf_idx_q[11:3]};
            2'b10:   LIST_INDEX = {2'b00, uf_idx_q[10:3]};
            default: LIST_INDEX = uf_idx_q[12:3];
        endcase
    end
    assign FRAME_INDEX = uf_idx_q;

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            run_q       <= STOPPED;
            enable_q    <= RST_ENABLE;
            pending_q   <= RST_PENDING;
            uf_idx_q    <= RST_UF_IDX;
            threshold_q <= RST_THRESHOLD;
            thr_cnt_q   <= 8'h00;
            list_size_q <= 2'b00;
            run_bit_q   <= 1'b0;
            irq_q       <= 1'b0;
            tick_cnt_q  <= 13'h0000;
            rdata_q     <= 32'h0000_0000;
        end else begin
            run_q       <= run_d;
            enable_q    <= enable_d;
            pending_q   <= pending_d;
            uf_idx_q    <= uf_idx_d;
            threshold_q <= threshold_d;
            thr_cnt_q   <= thr_cnt_d;
            list_size_q <= list_size_d;
            run_bit_q   <= run_bit_d;
            irq_q       <= irq_d;
            tick_cnt_q  <= tick_cnt_d;
            rdata_q     <= rdata_d;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    a_irq_needs_source: assert property (@(posedge CLK_SYS) disable iff (RST)
        IRQ |-> $past(active) != '0) else $error("irq without enabled source");
    a_immediate_irq: assert property (@(posedge CLK_SYS) disable iff (RST)
        |(active & ~THR_GOVERNED) |=> IRQ) else $error("immediate source not raised");
    a_irq_falls_clear: assert property (@(posedge CLK_SYS) disable iff (RST)
        (active == '0) |=> !IRQ) else $error("irq stayed with nothing pending");
    a_flag_poll_kept: assert property (@(posedge CLK_SYS) disable iff (RST)
        (ev_s2_q[BIT_XFER_DONE]) |=> pending_q[BIT_XFER_DONE]) else $error("flag lost");
    a_write_one_clear: assert property (@(posedge CLK_SYS) disable iff (RST)
        (wr_en && req.addr == OFF_STATUS && req.wdata[0] && !set_vec[0]) |=> !pending_q[0])
        else $error("flag not cleared");
    a_index_locked: assert property (@(posedge CLK_SYS) disable iff (RST)
        (run_q == RUNNING && !tick) |=> $stable(uf_idx_q)) else $error("index changed while running");
    a_tick_advance: assert property (@(posedge CLK_SYS) disable iff (RST)
        tick |=> uf_idx_q == $past(uf_idx_q) + 14'h0001) else $error("index did not advance");
    a_stopped_flag: assert property (@(posedge CLK_SYS) disable iff (RST)
        run_bit_q |=> run_q == RUNNING) else $error("stopped while run set");
    a_thr_one_now: assert property (@(posedge CLK_SYS) disable iff (RST)
        (threshold_q == 8'h01 && active != '0) |=> IRQ) else $error("threshold one delayed");
    a_index_write: assert property (@(posedge CLK_SYS) disable iff (RST)
        (wr_en && req.addr == OFF_UF_IDX && halted) |=> FRAME_INDEX == 14'($past(PWDATA)))
        else $error("index write lost while halted");
    a_wrap_irq: assert property (@(posedge CLK_SYS) disable iff (RST)
        (enable_q[BIT_LIST_WRAP] && pending_q[BIT_LIST_WRAP]) |=> IRQ) else $error("list wrap not raised");
    a_port_irq: assert property (@(posedge CLK_SYS) disable iff (RST)
        (enable_q[BIT_PORT_CHG] && pending_q[BIT_PORT_CHG]) |=> IRQ) else $error("port change not raised");
    a_wrap_flag: assert property (@(posedge CLK_SYS) disable iff (RST)
        (tick && list_size_q == 2'b10 && uf_idx_q[10:0] == 11'h7FF) |=> pending_q[BIT_LIST_WRAP]) else $error("wrap flag missed");
    a_err_flag_kept: assert property (@(posedge CLK_SYS) disable iff (RST)
        ev_s2_q[BIT_XFER_ERR] |=> pending_q[BIT_XFER_ERR]) else $error("error flag lost");
    a_stop_follows: assert property (@(posedge CLK_SYS) disable iff (RST)
        (!run_bit_q && run_q == RUNNING) |=> run_q == STOPPED) else $error("controller did not stop");

    // governed sources wait for a boundary
    sequence s_governed_wait;
        (active & ~THR_GOVERNED) == '0 && (active & THR_GOVERNED) != '0 && !boundary && !irq_q;
    endsequence
    sequence s_governed_edge;
        (active & THR_GOVERNED) != '0 && boundary;
    endsequence
    a_thr_deferred: assert property (@(posedge CLK_SYS) disable iff (RST)
        s_governed_wait |=> !IRQ) else $error("governed source not deferred");
    a_thr_release: assert property (@(posedge CLK_SYS) disable iff (RST)
        s_governed_edge |=> IRQ) else $error("governed source missed boundary");
endmodule
`default_nettype wire

// >>> verification/host_cpu_model.sv
// Host processor model: APB master through which software reaches the block
`timescale 1ns/10ps
`default_nettype none
module host_cpu_model (
    input  wire logic        clk_sys,
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [7:0]  paddr,
    output var  logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready
);
    // ****************************************
    // Idle bus
    // ****************************************
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h00000000;
    end
    // ****************************************
    // One transfer, caller sits just after an edge
    // ****************************************
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // No fixed latency assumed, only the bench watchdog ends this
        do @(posedge clk_sys); while (pready !== 1'b1);
        q = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Released data must not look valid
        pwdata  <= ~d;
        @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the interrupt enable and frame index block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import irq_frame_pkg::*;
    logic              clk_sys, rst, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]        paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic [SRC_W-1:0]  event_pulse;
    logic [FRIDX_W-1:0] frame_index, fi;
    logic [9:0]        list_index;
    int fails, total_checks, exp_en, exp_pend, i, n, sz;
    irq_frame_core i_irq_frame_core (.CLK_SYS(clk_sys), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .EVENT_PULSE(event_pulse), .IRQ(irq), .FRAME_INDEX(frame_index),
        .LIST_INDEX(list_index));
    host_cpu_model i_host_cpu_model (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));
    // ****************************************
    // Clock, reset, watchdog
    // ****************************************
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (40000) @(posedge clk_sys);
        fails++;
        tally_and_finish();
    end
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_host_cpu_model.apb(1'b1, a, d, rd);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        i_host_cpu_model.apb(1'b0, a, 32'h00000000, v);
        check(v, exp);
    endtask
    // Registered path: let pending and line settle first
    task automatic irq_chk();
        repeat (2) @(posedge clk_sys);
        check({31'h0, irq}, 32'((exp_en & exp_pend) != 0));
    endtask
    task automatic fire(input int b);
        event_pulse <= SRC_W'(1 << b);
        @(posedge clk_sys);
        event_pulse <= '0;
        repeat (6) @(posedge clk_sys);
        exp_pend |= 1 << b;
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst = 1'b1;
        event_pulse = '0;
        n = $urandom(85010);
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rd_chk(OFF_ENABLE, 32'h0);
        rd_chk(OFF_UF_IDX, 32'h0);
        rd_chk(OFF_STATUS, 32'h1000);
        rd_chk(8'h30, 32'h0);
        check({31'h0, pslverr}, 32'h0);
        n = $urandom;
        wr(OFF_ENABLE, n);
        exp_en = n & 32'h3F;
        rd_chk(OFF_ENABLE, exp_en);
        wr(OFF_ENABLE, 32'h0);
        exp_en = 0;
        for (i = 0; i < SRC_W; i++) begin
            fire(i);
            irq_chk();
        end
        rd_chk(OFF_STATUS, 32'h103F);
        wr(OFF_STATUS, 32'h3F);
        exp_pend = 0;
        wr(OFF_ENABLE, 32'h3F);
        exp_en = 32'h3F;
        for (i = 0; i < SRC_W; i++) begin
            fire(i);
            irq_chk();
            wr(OFF_STATUS, 32'h0);
            rd_chk(OFF_STATUS, 32'h1000 | exp_pend);
            wr(OFF_STATUS, 32'(1 << i));
            exp_pend = 0;
            irq_chk();
        end
        // Halted, so index writes land; sweep list sizes
        for (sz = 0; sz < 4; sz++) begin
            fi = FRIDX_W'($urandom);
            wr(OFF_CONTROL, 32'h00010000 | (sz << 2));
            wr(OFF_UF_IDX, 32'hFFFFC000 | fi);
            rd_chk(OFF_UF_IDX, fi);
            n = (sz == 3) ? 12 : 12 - sz;
            check({22'h0, list_index}, (fi >> 3) & ((1 << (n - 2)) - 1));
        end
        wr(OFF_CONTROL, 32'h00010008);
        wr(OFF_UF_IDX, 32'h7FF);
        wr(OFF_CONTROL, 32'h00010009);
        rd_chk(OFF_STATUS, 32'h0);
        wr(OFF_UF_IDX, 32'h0);
        rd_chk(OFF_UF_IDX, 32'h7FF);
        n = 0;
        while (frame_index === 14'h07FF && n < 3000) begin
            @(posedge clk_sys);
            n++;
        end
        check(frame_index, 32'h800);
        check({22'h0, list_index}, 32'h0);
        exp_pend = 8;
        irq_chk();
        n = 2;
        while (frame_index === 14'h0800 && n < 3000) begin
            @(posedge clk_sys);
            n++;
        end
        check(n, 2500);
        wr(OFF_CONTROL, 32'h00010008);
        rd_chk(OFF_STATUS, 32'h1008);
        rd_chk(OFF_UF_IDX, 32'h801);
        // Long threshold: governed sources wait, immediate ones do not
        wr(OFF_CONTROL, 32'h00FF0008);
        wr(OFF_STATUS, 32'h3F);
        exp_pend = 0;
        irq_chk();
        fire(BIT_SYS_ERR);
        irq_chk();
        for (i = 0; i < SRC_W; i++) begin
            wr(OFF_STATUS, 32'h3F);
            exp_pend = 0;
            irq_chk();
            if (THR_GOVERNED[i]) begin
                fire(i);
                n = 0;
                while (irq !== 1'b1 && n < 300) begin
                    @(posedge clk_sys);
                    n++;
                end
                check(32'(n < 256), 32'h1);
            end
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
